/* File: src/bdc_pkg.sv */
// Constants, types and encodings shared by the bitmap display controller
// Behaviour
// - Sync generator makes an interlaced 875-line, 60-field raster, 606 by 808 visible.
// - List head word points to the first control block; zero turns display off.
// - Each field the mask word after the head is ORed into pending interrupts.
// - Control word 1 bit 15 picks resolution, bit 14 picks polarity.
// - Each line of a block starts with sixteen times left-margin blank bits.
// - Words per line is even; zero gives blank lines with no bitmap fetch.
// - Control word 3 count covers that many lines in each field.
// - Vertical retrace reads head and mask, interrupts; field start then walks blocks in order.
// - High resolution: odd field starts one line later; lines step two lengths.
// - Low resolution: half-speed bits, each line in both fields, one-length steps.
// - Buffer load function, word task only, fills the sixteen-word data buffer.
// - Bit clock stops in blanking; its period is 50 ns or 100 ns.
// - Line mode function: bit 15 picks slow clock next line and branches; bit 14 polarity.
// - Field parity function branches when the display is in the even field.
// - Vertical task wakes at vertical retrace; horizontal at field start and word block.
// - Horizontal task self-block stops both it and word task until next field.
// - Word task wakes only when unblocked, horizontal unblocked, buffer not full.
// - Each horizontal retrace empties the buffer and clears the word block flag.
// - Wakeup priority: vertical, then horizontal, then word task.
// - Cursor shift register merges at the loaded x; size independent of resolution.
package bdc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int FIELD_HZ = 60;
  localparam int TOTAL_LINES = 875;
  localparam int VIS_POINTS = 606;
  localparam int VIS_LINES = 808;
  localparam int BIT_FAST_NS = 50;
  localparam int BIT_SLOW_NS = 100;
  localparam int HRET_NS = 6000;
  localparam int HSYNC_NS = 4000;
  localparam int VSYNC_LINES_N = 3;
  // Derived counts
  localparam int LINE_CYC = CLK_HZ * 2 / (FIELD_HZ * TOTAL_LINES);
  localparam int BIT_FAST_CYC = BIT_FAST_NS / CLK_NS;
  localparam int BIT_SLOW_CYC = BIT_SLOW_NS / CLK_NS;
  localparam int HRET_CYC = HRET_NS / CLK_NS;
  localparam int HSYNC_CYC = HSYNC_NS / CLK_NS;
  localparam int ACTIVE_CYC = VIS_POINTS * BIT_FAST_CYC;
  localparam logic [11:0] LINE_LAST = 12'(LINE_CYC - 1);
  localparam logic [11:0] HALF_LINE = 12'(LINE_CYC / 2);
  localparam logic [11:0] ACT_START = 12'(HRET_CYC);
  localparam logic [11:0] ACT_END = 12'(HRET_CYC + ACTIVE_CYC);
  localparam logic [11:0] HSYNC_END = 12'(HSYNC_CYC);
  localparam logic [3:0] FAST_LAST = 4'(BIT_FAST_CYC - 1);
  localparam logic [3:0] SLOW_LAST = 4'(BIT_SLOW_CYC - 1);
  localparam logic [8:0] EVEN_LAST = 9'((TOTAL_LINES + 1) / 2 - 1);
  localparam logic [8:0] ODD_LAST = 9'(TOTAL_LINES / 2 - 1);
  localparam logic [8:0] VIS_FIELD = 9'(VIS_LINES / 2);
  localparam logic [1:0] VSYNC_LINES = 2'(VSYNC_LINES_N);
  // Fixed memory words
  localparam logic [15:0] LIST_HEAD_ADDR = 16'h0110;
  localparam logic [15:0] LIST_MASK_ADDR = 16'h0111;
  // Control word 1 fields
  localparam int MODE_LOWRES_BIT = 15;
  localparam int MODE_POL_BIT = 14;
  localparam int MARGIN_HI = 13;
  localparam int MARGIN_LO = 8;
  localparam int WORDS_HI = 7;
  localparam int WORDS_LO = 0;
  // Task function codes
  localparam logic [3:0] F2_BUFFER_LOAD = 4'h8;
  localparam logic [3:0] F2_PARITY = 4'h8;
  localparam logic [3:0] F2_LINE_MODE = 4'h9;
  typedef enum logic [1:0] {
    BDC_TASK_NONE = 2'h0,
    BDC_TASK_VERT = 2'h1,
    BDC_TASK_HORIZ = 2'h2,
    BDC_TASK_WORD = 2'h3
  } bdc_task_t;
  // Register port
  localparam logic [4:0] REG_PTR_X = 5'h00;
  localparam logic [4:0] REG_PTR_Y = 5'h01;
  localparam logic [4:0] REG_STATUS = 5'h02;
  localparam int REG_MAP_BIT = 4;
  localparam logic [15:0] PTR_X_RST = 16'hffff;
  localparam logic [15:0] PTR_Y_RST = 16'h0000;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_V_HEAD = 11'h002,
    ST_V_MASK = 11'h004,
    ST_H_CHECK = 11'h008,
    ST_H_LINK = 11'h010,
    ST_H_MODE = 11'h020,
    ST_H_START = 11'h040,
    ST_H_COUNT = 11'h080,
    ST_H_LINE = 11'h100,
    ST_W_WORD = 11'h200,
    ST_W_FETCH = 11'h400
  } bdc_state_t;
endpackage : bdc_pkg

/* File: src/bdc_display.sv */
// Bitmap display controller: sync, list walker, buffer, serializer, cursor
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module bdc_display (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Memory read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Pending interrupt word OR request
  output logic irq_or_valid,
  output logic [15:0] irq_or_mask,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Monitor
  output logic video_out,
  output logic hsync_out,
  output logic vsync_out,
  output logic blank_out
);
  logic [11:0] hcnt_reg;
  logic [8:0] line_reg;
  logic field_odd_reg;
  logic [1:0] vs_left_reg;
  logic line_start;
  logic vblank;
  logic active;
  logic field_start;
  logic vret_start;
  logic [11:0] vs_phase;
  logic low_res_reg;
  logic low_res_next_reg;
  logic polarity_reg;
  logic [3:0] div_reg;
  logic [3:0] pix_div_reg;
  logic bit_tick;
  logic pix_tick;
  logic [15:0] buf_mem [16];
  logic [4:0] wr_ptr_reg;
  logic [4:0] rd_ptr_reg;
  logic [4:0] buf_count;
  logic buf_full;
  logic buf_empty;
  logic buf_load;
  logic buf_pop;
  logic [15:0] sh_reg;
  logic [3:0] sh_cnt_reg;
  logic pix_reg;
  logic [15:0] buf_head;
  logic [15:0] ptr_x_reg;
  logic [15:0] ptr_y_reg;
  logic [15:0] ptr_map [16];
  logic [15:0] cur_sh_reg;
  logic [15:0] cur_x_reg;
  logic cur_bit_reg;
  logic [15:0] cur_dy;
  logic active_d_reg;
  logic vt_pend_reg;
  logic ht_pend_reg;
  logic ht_blocked_reg;
  logic wt_blocked_reg;
  logic ht_wake;
  logic wt_wake;
  bdc_pkg::bdc_state_t state_reg;
  logic [15:0] block_ptr_reg;
  logic [15:0] blk_addr_reg;
  logic [15:0] mode_word_reg;
  logic [15:0] start_reg;
  logic [15:0] pair_count_reg;
  logic [15:0] line_base_reg;
  logic [15:0] fetch_addr_reg;
  logic [15:0] line_end_reg;
  logic [5:0] margin_reg;
  logic first_line_reg;
  logic fn_valid;
  bdc_pkg::bdc_task_t fn_task;
  logic [3:0] fn_code;
  logic [15:0] fn_bus;
  logic mode_set;
  logic parity_test;
  logic next_bit9;
  logic [15:0] words;
  logic [15:0] base_calc;

  // Sync generator
  assign line_start = (hcnt_reg == 12'h000);
  assign vblank = (line_reg >= bdc_pkg::VIS_FIELD);
  assign field_start = line_start && (line_reg == 9'h000);
  assign vret_start = line_start && (line_reg == bdc_pkg::VIS_FIELD);
  assign active = !vblank && (hcnt_reg >= bdc_pkg::ACT_START) && (hcnt_reg < bdc_pkg::ACT_END);
  assign vs_phase = field_odd_reg ? bdc_pkg::HALF_LINE : 12'h000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hcnt_reg <= 12'h000;
    end else if (hcnt_reg == bdc_pkg::LINE_LAST) begin
      hcnt_reg <= 12'h000;
    end else begin
      hcnt_reg <= hcnt_reg + 12'h001;
    end
  end

  // Reset parks on the last odd-field line so a field begins within one line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_reg <= bdc_pkg::ODD_LAST;
      field_odd_reg <= 1'b1;
    end else if (hcnt_reg == bdc_pkg::LINE_LAST) begin
      if (line_reg == (field_odd_reg ? bdc_pkg::ODD_LAST : bdc_pkg::EVEN_LAST)) begin
        line_reg <= 9'h000;
        field_odd_reg <= !field_odd_reg;
      end else begin
        line_reg <= line_reg + 9'h001;
      end
    end
  end

  // Odd field sync starts half a line late for interlace
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vs_left_reg <= 2'h0;
    end else if (line_reg == bdc_pkg::VIS_FIELD && hcnt_reg == vs_phase) begin
      vs_left_reg <= bdc_pkg::VSYNC_LINES;
    end else if (hcnt_reg == vs_phase && vs_left_reg != 2'h0) begin
      vs_left_reg <= vs_left_reg - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      blank_out <= 1'b1;
      active_d_reg <= 1'b0;
    end else begin
      hsync_out <= (hcnt_reg < bdc_pkg::HSYNC_END);
      vsync_out <= (vs_left_reg != 2'h0);
      blank_out <= !active_d_reg;
      active_d_reg <= active;
    end
  end

  // Bit clock: resolution switches only at line start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_res_reg <= 1'b0;
    end else if (line_start) begin
      low_res_reg <= low_res_next_reg;
    end
  end

  assign bit_tick = active && (div_reg == 4'h0);
  assign pix_tick = active && (pix_div_reg == 4'h0);

  always_ff @(posedge sys_clk) begin
    if (rst || !active) begin
      div_reg <= 4'h0;
      pix_div_reg <= 4'h0;
    end else begin
      div_reg <= (div_reg == (low_res_reg ? bdc_pkg::SLOW_LAST : bdc_pkg::FAST_LAST)) ? 4'h0 : div_reg + 4'h1;
      pix_div_reg <= (pix_div_reg == bdc_pkg::FAST_LAST) ? 4'h0 : pix_div_reg + 4'h1;
    end
  end

  // Data buffer
  assign buf_count = wr_ptr_reg - rd_ptr_reg;
  assign buf_full = buf_count[4];
  assign buf_empty = (buf_count == 5'h00);
  assign buf_pop = bit_tick && (sh_cnt_reg == 4'h0) && !buf_empty;
  assign buf_head = buf_empty ? 16'h0000 : buf_mem[rd_ptr_reg[3:0]];

  always_ff @(posedge sys_clk) begin
    if (rst || line_start) begin
      wr_ptr_reg <= 5'h00;
      rd_ptr_reg <= 5'h00;
    end else begin
      if (buf_load) begin
        wr_ptr_reg <= wr_ptr_reg + 5'h01;
      end
      if (buf_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (buf_load) begin
      buf_mem[wr_ptr_reg[3:0]] <= fn_bus;
    end
  end

  // Serializer; an empty buffer shows background
  always_ff @(posedge sys_clk) begin
    if (rst || line_start) begin
      sh_reg <= 16'h0000;
      sh_cnt_reg <= 4'h0;
      pix_reg <= 1'b0;
    end else if (!active) begin
      pix_reg <= 1'b0;
    end else if (bit_tick) begin
      if (sh_cnt_reg == 4'h0) begin
        pix_reg <= buf_head[15];
        sh_reg <= {buf_head[14:0], 1'b0};
        sh_cnt_reg <= 4'hf;
      end else begin
        pix_reg <= sh_reg[15];
        sh_reg <= {sh_reg[14:0], 1'b0};
        sh_cnt_reg <= sh_cnt_reg - 4'h1;
      end
    end
  end

  // Cursor runs on fixed 50 ns ticks
  assign cur_dy = {6'h00, line_reg, field_odd_reg} - ptr_y_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_sh_reg <= 16'h0000;
      cur_x_reg <= 16'h0000;
      cur_bit_reg <= 1'b0;
    end else if (line_start) begin
      cur_sh_reg <= (cur_dy < 16'h0010) ? ptr_map[cur_dy[3:0]] : 16'h0000;
      cur_x_reg <= 16'h0000;
      cur_bit_reg <= 1'b0;
    end else if (!active) begin
      cur_bit_reg <= 1'b0;
    end else if (pix_tick) begin
      cur_x_reg <= cur_x_reg + 16'h0001;
      if (cur_x_reg >= ptr_x_reg) begin
        cur_bit_reg <= cur_sh_reg[15];
        cur_sh_reg <= {cur_sh_reg[14:0], 1'b0};
      end else begin
        cur_bit_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      video_out <= 1'b0;
    end else begin
      // Polarity 0 shows dark data on a lit background
      video_out <= active_d_reg && !(polarity_reg ^ (pix_reg | cur_bit_reg));
    end
  end

  // Task function decode
  always_comb begin
    fn_valid = 1'b0;
    fn_task = bdc_pkg::BDC_TASK_NONE;
    fn_code = 4'h0;
    fn_bus = 16'h0000;
    if (state_reg == bdc_pkg::ST_W_WORD && margin_reg != 6'h00) begin
      fn_valid = 1'b1;
      fn_task = bdc_pkg::BDC_TASK_WORD;
      fn_code = bdc_pkg::F2_BUFFER_LOAD;
    end else if (state_reg == bdc_pkg::ST_W_FETCH && mem_ack) begin
      fn_valid = 1'b1;
      fn_task = bdc_pkg::BDC_TASK_WORD;
      fn_code = bdc_pkg::F2_BUFFER_LOAD;
      fn_bus = mem_rdata;
    end else if (state_reg == bdc_pkg::ST_H_MODE && mem_ack) begin
      fn_valid = 1'b1;
      fn_task = bdc_pkg::BDC_TASK_HORIZ;
      fn_code = bdc_pkg::F2_LINE_MODE;
      fn_bus = mem_rdata;
    end else if (state_reg == bdc_pkg::ST_H_LINE) begin
      fn_valid = 1'b1;
      fn_task = bdc_pkg::BDC_TASK_HORIZ;
      fn_code = bdc_pkg::F2_PARITY;
    end
  end

  assign buf_load = fn_valid && fn_task == bdc_pkg::BDC_TASK_WORD && fn_code == bdc_pkg::F2_BUFFER_LOAD
    && !buf_full;
  assign mode_set = fn_valid && fn_task == bdc_pkg::BDC_TASK_HORIZ && fn_code == bdc_pkg::F2_LINE_MODE;
  assign parity_test = fn_valid && fn_code == bdc_pkg::F2_PARITY
    && (fn_task == bdc_pkg::BDC_TASK_HORIZ || fn_task == bdc_pkg::BDC_TASK_VERT);
  assign next_bit9 = (mode_set && fn_bus[bdc_pkg::MODE_LOWRES_BIT]) || (parity_test && !field_odd_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_res_next_reg <= 1'b0;
      polarity_reg <= 1'b0;
    end else if (mode_set) begin
      low_res_next_reg <= fn_bus[bdc_pkg::MODE_LOWRES_BIT];
      polarity_reg <= fn_bus[bdc_pkg::MODE_POL_BIT];
    end
  end

  // Wakeups
  assign ht_wake = ht_pend_reg && !ht_blocked_reg;
  assign wt_wake = !wt_blocked_reg && !ht_blocked_reg && !buf_full && !vblank;

  // Vertical task runs once out of reset to load the list before the field
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vt_pend_reg <= 1'b1;
    end else if (vret_start) begin
      vt_pend_reg <= 1'b1;
    end else if (state_reg == bdc_pkg::ST_V_MASK && mem_ack) begin
      vt_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ht_pend_reg <= 1'b0;
      ht_blocked_reg <= 1'b1;
    end else if (field_start) begin
      ht_pend_reg <= 1'b1;
      ht_blocked_reg <= 1'b0;
    end else begin
      if ((state_reg == bdc_pkg::ST_W_WORD && margin_reg == 6'h00 && fetch_addr_reg == line_end_reg)
          || (state_reg == bdc_pkg::ST_W_FETCH && mem_ack && fetch_addr_reg + 16'h0001 == line_end_reg)) begin
        ht_pend_reg <= 1'b1;
      end else if (state_reg == bdc_pkg::ST_IDLE && !vt_pend_reg && ht_wake) begin
        ht_pend_reg <= 1'b0;
      end
      if (state_reg == bdc_pkg::ST_V_MASK && mem_ack) begin
        ht_blocked_reg <= 1'b1;
      end else if (state_reg == bdc_pkg::ST_H_CHECK && pair_count_reg == 16'h0000
          && block_ptr_reg == 16'h0000) begin
        ht_blocked_reg <= 1'b1;
      end
    end
  end

  // Word block set wins over the retrace clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wt_blocked_reg <= 1'b0;
    end else if ((state_reg == bdc_pkg::ST_W_WORD && margin_reg == 6'h00 && fetch_addr_reg == line_end_reg)
        || (state_reg == bdc_pkg::ST_W_FETCH && mem_ack && fetch_addr_reg + 16'h0001 == line_end_reg)) begin
      wt_blocked_reg <= 1'b1;
    end else if (line_start) begin
      wt_blocked_reg <= 1'b0;
    end
  end

  // Line address arithmetic
  assign words = {8'h00, mode_word_reg[bdc_pkg::WORDS_HI:bdc_pkg::WORDS_LO]};
  always_comb begin
    if (first_line_reg) begin
      base_calc = start_reg + ((mode_word_reg[bdc_pkg::MODE_LOWRES_BIT] || next_bit9) ? 16'h0000 : words);
    end else if (mode_word_reg[bdc_pkg::MODE_LOWRES_BIT]) begin
      base_calc = line_base_reg + words;
    end else begin
      base_calc = line_base_reg + {words[14:0], 1'b0};
    end
  end

  // Display list engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= bdc_pkg::ST_IDLE;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
      irq_or_valid <= 1'b0;
      irq_or_mask <= 16'h0000;
      block_ptr_reg <= 16'h0000;
      blk_addr_reg <= 16'h0000;
      mode_word_reg <= 16'h0000;
      start_reg <= 16'h0000;
      pair_count_reg <= 16'h0000;
      line_base_reg <= 16'h0000;
      fetch_addr_reg <= 16'h0000;
      line_end_reg <= 16'h0000;
      margin_reg <= 6'h00;
      first_line_reg <= 1'b0;
    end else begin
      irq_or_valid <= 1'b0;
      case (state_reg)
        bdc_pkg::ST_IDLE: begin
          if (vt_pend_reg) begin
            mem_req <= 1'b1;
            mem_addr <= bdc_pkg::LIST_HEAD_ADDR;
            state_reg <= bdc_pkg::ST_V_HEAD;
          end else if (ht_wake) begin
            state_reg <= bdc_pkg::ST_H_CHECK;
          end else if (wt_wake) begin
            state_reg <= bdc_pkg::ST_W_WORD;
          end
        end
        bdc_pkg::ST_V_HEAD: begin
          if (mem_ack) begin
            block_ptr_reg <= mem_rdata;
            mem_addr <= bdc_pkg::LIST_MASK_ADDR;
            state_reg <= bdc_pkg::ST_V_MASK;
          end
        end
        bdc_pkg::ST_V_MASK: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            irq_or_valid <= 1'b1;
            irq_or_mask <= mem_rdata;
            pair_count_reg <= 16'h0000;
            state_reg <= bdc_pkg::ST_IDLE;
          end
        end
        bdc_pkg::ST_H_CHECK: begin
          if (pair_count_reg != 16'h0000) begin
            state_reg <= bdc_pkg::ST_H_LINE;
          end else if (block_ptr_reg == 16'h0000) begin
            state_reg <= bdc_pkg::ST_IDLE;
          end else begin
            blk_addr_reg <= block_ptr_reg;
            mem_req <= 1'b1;
            mem_addr <= block_ptr_reg;
            state_reg <= bdc_pkg::ST_H_LINK;
          end
        end
        bdc_pkg::ST_H_LINK: begin
          if (mem_ack) begin
            block_ptr_reg <= mem_rdata;
            mem_addr <= blk_addr_reg + 16'h0001;
            state_reg <= bdc_pkg::ST_H_MODE;
          end
        end
        bdc_pkg::ST_H_MODE: begin
          if (mem_ack) begin
            mode_word_reg <= mem_rdata;
            mem_addr <= blk_addr_reg + 16'h0002;
            state_reg <= bdc_pkg::ST_H_START;
          end
        end
        bdc_pkg::ST_H_START: begin
          if (mem_ack) begin
            start_reg <= mem_rdata;
            mem_addr <= blk_addr_reg + 16'h0003;
            state_reg <= bdc_pkg::ST_H_COUNT;
          end
        end
        bdc_pkg::ST_H_COUNT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            pair_count_reg <= mem_rdata;
            first_line_reg <= 1'b1;
            state_reg <= bdc_pkg::ST_H_CHECK;
          end
        end
        bdc_pkg::ST_H_LINE: begin
          pair_count_reg <= pair_count_reg - 16'h0001;
          margin_reg <= mode_word_reg[bdc_pkg::MARGIN_HI:bdc_pkg::MARGIN_LO];
          line_base_reg <= base_calc;
          fetch_addr_reg <= base_calc;
          line_end_reg <= base_calc + words;
          first_line_reg <= 1'b0;
          state_reg <= bdc_pkg::ST_IDLE;
        end
        bdc_pkg::ST_W_WORD: begin
          if (margin_reg != 6'h00) begin
            margin_reg <= margin_reg - 6'h01;
            state_reg <= bdc_pkg::ST_IDLE;
          end else if (fetch_addr_reg == line_end_reg) begin
            state_reg <= bdc_pkg::ST_IDLE;
          end else begin
            mem_req <= 1'b1;
            mem_addr <= fetch_addr_reg;
            state_reg <= bdc_pkg::ST_W_FETCH;
          end
        end
        bdc_pkg::ST_W_FETCH: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            fetch_addr_reg <= fetch_addr_reg + 16'h0001;
            state_reg <= bdc_pkg::ST_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          state_reg <= bdc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_x_reg <= bdc_pkg::PTR_X_RST;
      ptr_y_reg <= bdc_pkg::PTR_Y_RST;
    end else if (reg_wr) begin
      if (reg_addr == bdc_pkg::REG_PTR_X) begin
        ptr_x_reg <= reg_wdata;
      end else if (reg_addr == bdc_pkg::REG_PTR_Y) begin
        ptr_y_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reg_wr && reg_addr[bdc_pkg::REG_MAP_BIT]) begin
      ptr_map[reg_addr[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr[bdc_pkg::REG_MAP_BIT]) begin
      reg_rdata <= ptr_map[reg_addr[3:0]];
    end else if (reg_addr == bdc_pkg::REG_PTR_X) begin
      reg_rdata <= ptr_x_reg;
    end else if (reg_addr == bdc_pkg::REG_PTR_Y) begin
      reg_rdata <= ptr_y_reg;
    end else if (reg_addr == bdc_pkg::REG_STATUS) begin
      reg_rdata <= {5'h00, buf_count, polarity_reg, low_res_reg, wt_blocked_reg, ht_blocked_reg,
        vblank, field_odd_reg};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : bdc_display

/* File: tb/bdc_display_props.sv */
// Port checker for the bitmap display controller
`timescale 1ns/1ns
module bdc_display_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Memory and interrupt
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic irq_or_valid,
  input wire logic [15:0] irq_or_mask,
  // Monitor
  input wire logic video_out,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic blank_out
);
  logic [11:0] cnt_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Cycles since sync rise; preset so the first rise after reset matches
  always_ff @(posedge sys_clk) begin
    if (rst) cnt_reg <= 12'hedf;
    else if ($rose(hsync_out)) cnt_reg <= 12'h000;
    else cnt_reg <= cnt_reg + 12'h001;
  end
  a_line_period: assert property ($rose(hsync_out) |-> cnt_reg == 12'hee0)
    else $error("bad line period");
  a_sync_width: assert property ($fell(hsync_out) |-> cnt_reg == 12'h18f)
    else $error("bad sync width");
  a_blank_dark: assert property (blank_out |-> !video_out)
    else $error("video in blanking");
  a_vsync_blank: assert property ($rose(vsync_out) |-> blank_out)
    else $error("vsync while visible");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request not held");
  a_irq_pulse: assert property (irq_or_valid |=> !irq_or_valid)
    else $error("long interrupt pulse");
  a_irq_cause: assert property (irq_or_valid |-> $past(mem_ack) && irq_or_mask == $past(mem_rdata))
    else $error("interrupt without mask");
  a_head_mask: assert property (mem_req && mem_ack && mem_addr == 16'h0110 |=> mem_req && mem_addr == 16'h0111)
    else $error("mask not after head");
endmodule : bdc_display_props
bind bdc_display bdc_display_props u_props (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_or_valid(irq_or_valid), .irq_or_mask(irq_or_mask),
  .video_out(video_out), .hsync_out(hsync_out), .vsync_out(vsync_out), .blank_out(blank_out));

/* File: tb/bdc_mem_model.sv */
// Main memory holding the display list and bitmap
`timescale 1ns/1ns
module bdc_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Read port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:1023];
  logic [1:0] wait_reg;
  always_ff @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    // Stale data flips every cycle, so it matches the last read word only on alternate cycles
    mem_rdata <= rst ? 16'h0000 : ~mem_rdata;
    if (rst || !mem_req || mem_ack) begin
      wait_reg <= 2'h0;
    end else if (wait_reg == lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:0]];
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule : bdc_mem_model

/* File: tb/bdc_display_bench.sv */
// Bench for the bitmap display controller
`timescale 1ns/1ns
module bdc_display_bench;
  logic sys_clk, rst, mem_req, mem_ack, reg_wr, reg_rd, video_out, hsync_out, vsync_out, blank_out, irq_or_valid;
  logic [15:0] mem_addr, mem_rdata, reg_wdata, reg_rdata, irq_or_mask;
  logic [4:0] reg_addr;
  logic [1:0] lat;
  logic [15:0] bm_q[$];
  int n_errors, n_tests, cyc, first, high;
  bdc_display uut (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq_or_valid(irq_or_valid), .irq_or_mask(irq_or_mask), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_out(video_out),
    .hsync_out(hsync_out), .vsync_out(vsync_out), .blank_out(blank_out));
  bdc_mem_model mdl (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  // Bitmap fetches and run limit
  always @(posedge sys_clk) begin
    cyc++;
    if (mem_req && mem_ack && mem_addr >= 16'h0300) bm_q.push_back(mem_addr);
    if (cyc > 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd
  // First lit cycle and lit count of the next visible line
  task automatic line(input int f, input int h);
    first = -1;
    high = 0;
    while (blank_out !== 1'b1) @(negedge sys_clk);
    while (blank_out === 1'b1) @(negedge sys_clk);
    for (int i = 0; i < 3030; i++) begin
      if (video_out === 1'b1 && first < 0) first = i;
      if (video_out === 1'b1) high++;
      @(negedge sys_clk);
    end
    check(16'(first), 16'(f));
    check(16'(high), 16'(h));
  endtask : line
  task automatic t_irq;
    for (int i = 0; i < 200 && irq_or_valid !== 1'b1; i++) @(negedge sys_clk);
    check({15'h0000, irq_or_valid}, 16'h0001);
    check(irq_or_mask, 16'h00a5);
  endtask : t_irq
  task automatic t_regs;
    wr(5'h00, 16'h000a);
    wr(5'h01, 16'h0008);
    wr(5'h10, 16'hc000);
    rd(5'h00, 16'h000a);
    rd(5'h05, 16'h0000);
    rd(5'h10, 16'hc000);
    rd(5'h02, 16'h0007);
  endtask : t_regs
  task automatic t_screen;
    line(80, 20);
    lat <= 2'h3;
    line(235, 5);
    line(-1, 0);
    line(-1, 0);
    line(50, 10);
    check(16'(bm_q.size()), 16'h0004);
    foreach (bm_q[i]) check(bm_q[i], 16'h0300 + 16'(i) + ((i > 1) ? 16'h0002 : 16'h0000));
  endtask : t_screen
  initial begin
    rst = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lat = 2'h0;
    // Words of the wrong odd line are lit to expose a bad step
    for (int i = 0; i < 1024; i++) mdl.mem[i] = (i == 'h302 || i == 'h303) ? 16'hffff : 16'h0000;
    mdl.mem[10'h110] = 16'h0200;
    mdl.mem[10'h111] = 16'h00a5;
    mdl.mem[10'h201] = 16'h4102;
    mdl.mem[10'h202] = 16'h0300;
    mdl.mem[10'h203] = 16'h0002;
    mdl.mem[10'h300] = 16'hf000;
    mdl.mem[10'h305] = 16'h0001;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_irq();
    t_regs();
    t_screen();
    report_and_stop();
  end
endmodule : bdc_display_bench
